// ---- hw/lhs_core.sv ----
// Host serial port, mode strap and reset control of a quad line interface
`timescale 1ns/100ps
module lhs_core #(
  parameter int POR_LEN = lhs_pkg::POR_CYCLES,
  parameter bit MSB_FIRST = 1'b1
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic reference_clock_in_i,
  input wire logic hard_reset_n_i,
  input wire logic control_mode_strap_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clock_i,
  input wire logic serial_in_pin_i,
  input wire logic [lhs_pkg::NUM_CH-1:0] jitter_store_error_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  output logic hardware_mode_o,
  output logic [2:0] jitter_depth_select_o,
  output logic jitter_path_select_o,
  output logic in_reset_o,
  output logic host_outputs_enable_o,
  output logic hard_reset_hiz_o,
  output logic [lhs_pkg::NUM_CH-1:0] tx_clock_pin_dir_out_o,
  output logic [lhs_pkg::NUM_CH*lhs_pkg::DATA_W-1:0] chan_cfg_o,
  output logic [lhs_pkg::DATA_W-1:0] global_config_register_o
);
  import lhs_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic reference_clock_in_d1_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= 6'h17;
      sync2_q <= 6'h17;
    end else begin
      sync1_q <= {reference_clock_in_i, hard_reset_n_i,
                  control_mode_strap_i, chip_select_n_i,
                  serial_clock_i, serial_in_pin_i};
      sync2_q <= sync1_q;
    end
  end
  wire ref_s = sync2_q[5];
  wire hrst_n_s = sync2_q[4];
  wire strap_s = sync2_q[3];
  wire cs_n_s = sync2_q[2];
  wire sclk_s = sync2_q[1];
  wire sdi_s = sync2_q[0];

  // ---------------------------------------------------------------
  // Error flag synchroniser
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] jerr1_q;
  logic [NUM_CH-1:0] jerr2_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      jerr1_q <= '0;
      jerr2_q <= '0;
    end else begin
      jerr1_q <= jitter_store_error_i;
      jerr2_q <= jerr1_q;
    end
  end

  logic sclk_d1_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_d1_q <= 1'b1;
      reference_clock_in_d1_q <= 1'b0;
    end else begin
      sclk_d1_q <= sclk_s;
      reference_clock_in_d1_q <= ref_s;
    end
  end
  wire sclk_fall = sclk_d1_q & ~sclk_s;
  wire sclk_rise = ~sclk_d1_q & sclk_s;
  wire ref_edge = reference_clock_in_d1_q ^ ref_s;

  // ---------------------------------------------------------------
  // Mode strap
  // ---------------------------------------------------------------
  logic hw_mode_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hw_mode_q <= 1'b0;
    end else begin
      hw_mode_q <= strap_s;
    end
  end
  assign hardware_mode_o = hw_mode_q;

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  lhs_rst_state_t rst_st_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic por_q;
  logic soft_req;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_st_q <= LHS_RST_BUSY;
      rst_cnt_q <= '0;
      por_q <= 1'b1;
    end else begin
      case (rst_st_q)
        LHS_RST_IDLE: begin
          if (!hrst_n_s) begin
            rst_st_q <= LHS_RST_BUSY;
            rst_cnt_q <= '0;
            por_q <= 1'b0;
          end else if (soft_req) begin
            rst_st_q <= LHS_RST_BUSY;
            rst_cnt_q <= '0;
            por_q <= 1'b0;
          end
        end
        LHS_RST_BUSY: begin
          if (!hrst_n_s) begin
            rst_cnt_q <= '0;
          end else if (por_q) begin
            if (ref_edge) begin
              rst_cnt_q <= rst_cnt_q + 1'b1;
            end
            if (rst_cnt_q >= CNT_W'(POR_LEN - 1)) begin
              rst_st_q <= LHS_RST_IDLE;
              por_q <= 1'b0;
            end
          end else if (rst_cnt_q >= CNT_W'(RST_CYCLES - 1)) begin
            rst_st_q <= LHS_RST_IDLE;
          end else begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
          end
        end
        default: rst_st_q <= LHS_RST_BUSY;
      endcase
    end
  end
  wire in_rst = (rst_st_q == LHS_RST_BUSY);
  assign in_reset_o = in_rst;
  assign hard_reset_hiz_o = ~hrst_n_s;

  // ---------------------------------------------------------------
  // Serial shifter
  // ---------------------------------------------------------------
  logic [BITCNT_W-1:0] bit_cnt_q;
  logic [CTRL_BITS-1:0] ctrl_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] rd_q;
  logic sdo_q;
  logic wr_go;
  wire host_port = ~hw_mode_q & ~in_rst;
  wire rd_dir = ctrl_q[CTRL_BITS-1];
  logic [ADDR_W-1:0] addr_rev;
  always_comb begin
    addr_rev = {<<{ctrl_q[ADDR_W-1:0]}};
  end
  wire [ADDR_W-1:0] addr = MSB_FIRST ? ctrl_q[ADDR_W-1:0] : addr_rev;
  wire [DATA_W-1:0] wr_byte = MSB_FIRST ? {data_q[DATA_W-2:0], sdi_s}
                                        : {sdi_s, data_q[DATA_W-1:1]};
  logic [DATA_W-1:0] regs_q [NUM_REGS];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_q <= '0;
      ctrl_q <= '0;
      data_q <= '0;
    end else if (cs_n_s || !host_port) begin
      bit_cnt_q <= '0;
    end else if (sclk_fall && bit_cnt_q < BITCNT_W'(FRAME_BITS)) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
      if (bit_cnt_q < BITCNT_W'(CTRL_BITS)) begin
        ctrl_q <= {ctrl_q[CTRL_BITS-2:0], sdi_s};
      end else begin
        data_q <= wr_byte;
      end
    end
  end
  assign wr_go = host_port && !cs_n_s && sclk_fall && !rd_dir
    && bit_cnt_q == BITCNT_W'(FRAME_BITS - 1);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // soft reset bit written
  assign soft_req = wr_go && addr == GLOBAL_CONFIG_ADDR
    && wr_byte[SOFT_RESET_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          regs_q[gi] <= REG_DEFAULT;
        end else if (in_rst) begin
          regs_q[gi] <= REG_DEFAULT;
        end else if (wr_go && addr == ADDR_W'(gi)) begin
          regs_q[gi] <= wr_byte;
          if (ADDR_W'(gi) == GLOBAL_CONFIG_ADDR) begin
            regs_q[gi][SOFT_RESET_BIT] <= 1'b0;
          end
        end
      end
    end
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign chan_cfg_o[gi*DATA_W +: DATA_W] =
        regs_q[(gi + 1) * 16];
    end
  endgenerate
  assign global_config_register_o = regs_q[GLOBAL_CONFIG_ADDR];

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  wire [BITCNT_W-1:0] rd_idx = bit_cnt_q - BITCNT_W'(CTRL_BITS);
  wire [2:0] bsel = MSB_FIRST ? 3'(DATA_W - 1) - rd_idx[2:0]
                              : rd_idx[2:0];
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_q <= '0;
      sdo_q <= 1'b0;
    end else begin
      if (bit_cnt_q == BITCNT_W'(CTRL_BITS - 1) && sclk_fall) begin
        rd_q <= regs_q[{ctrl_q[ADDR_W-2:0], sdi_s}];
      end
      if (sclk_rise && bit_cnt_q >= BITCNT_W'(CTRL_BITS)
          && bit_cnt_q < BITCNT_W'(FRAME_BITS)) begin
        sdo_q <= rd_q[bsel];
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin sharing and output states
  // ---------------------------------------------------------------
  // drive in hardware mode, or in host read data
  assign serial_out_pin_oe_o = hrst_n_s && !in_rst && (hw_mode_q ||
    (host_port && !cs_n_s && rd_dir
     && bit_cnt_q >= BITCNT_W'(CTRL_BITS)));
  logic sout_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sout_q <= 1'b0;
    end else begin
      sout_q <= hw_mode_q ? jerr2_q[0] : sdo_q;
    end
  end
  assign serial_out_pin_o = sout_q;
  assign jitter_depth_select_o = {sdi_s, cs_n_s, 1'b0};
  assign jitter_path_select_o = sclk_s;
  assign host_outputs_enable_o = hw_mode_q & ~in_rst & hrst_n_s;
  assign tx_clock_pin_dir_out_o = '0;
endmodule

// ---- hw/lhs_pkg.sv ----
// Constants and types for the host serial port and reset control block
package lhs_pkg;
  localparam int CLK_MHZ = 40;
  // Reset sequence lengths
  localparam int POR_MAX_MS = 300;
  localparam int POR_CYCLES = POR_MAX_MS * 1000 * CLK_MHZ;
  localparam int RST_MAX_US = 5;
  localparam int RST_CYCLES = RST_MAX_US * CLK_MHZ;
  localparam int CNT_W = 24;
  // Serial frame layout
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int FRAME_BITS = 16;
  localparam int CTRL_BITS = 8;
  localparam int BITCNT_W = 5;
  localparam int NUM_REGS = 128;
  localparam int NUM_CH = 4;
  // Global configuration register and its soft reset bit
  localparam logic [6:0] GLOBAL_CONFIG_ADDR = 7'h01;
  localparam int SOFT_RESET_BIT = 0;
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  // Reset sequence states
  typedef enum logic [1:0] {
    LHS_RST_IDLE,
    LHS_RST_BUSY
  } lhs_rst_state_t;
endpackage

// ---- testbench/lhs_chk.sv ----
// Assertion checker bound to the serial port and reset control block
`timescale 1ns/100ps
module lhs_chk (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic hard_reset_n_i,
  input wire logic control_mode_strap_i,
  input wire logic chip_select_n_i,
  input wire logic [lhs_pkg::NUM_CH-1:0] jitter_store_error_i,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_o,
  input wire logic hardware_mode_o,
  input wire logic in_reset_o,
  input wire logic host_outputs_enable_o,
  input wire logic hard_reset_hiz_o,
  input wire logic [lhs_pkg::NUM_CH-1:0] tx_clock_pin_dir_out_o,
  input wire logic [lhs_pkg::NUM_CH*lhs_pkg::DATA_W-1:0] chan_cfg_o,
  input wire logic [lhs_pkg::DATA_W-1:0] global_config_register_o
);
  import lhs_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_strap_steady;
    $stable(control_mode_strap_i) [*5];
  endsequence
  sequence s_port_idle;
    (chip_select_n_i && !hardware_mode_o) [*4];
  endsequence
  sequence s_flag_steady;
    (hardware_mode_o && !in_reset_o && !hard_reset_hiz_o
      && $stable(jitter_store_error_i)) [*4];
  endsequence
  chk_strap_mode: assert property (
    s_strap_steady |-> hardware_mode_o == control_mode_strap_i)
    else $error("mode not from strap");
  chk_port_quiet: assert property (
    s_port_idle |-> !serial_out_pin_oe_o)
    else $error("serial out driven idle");
  chk_hiz_hold: assert property (
    hard_reset_hiz_o |-> !serial_out_pin_oe_o && !host_outputs_enable_o)
    else $error("driven in hard reset");
  chk_txclk_input: assert property (
    tx_clock_pin_dir_out_o == 4'h0)
    else $error("tx clock pin output");
  chk_regs_cleared: assert property (
    in_reset_o && $past(in_reset_o) |->
      chan_cfg_o == 32'h0 && global_config_register_o == 8'h00)
    else $error("register set in reset");
  chk_host_tristate: assert property (
    (!hardware_mode_o || in_reset_o) [*2] |-> !host_outputs_enable_o)
    else $error("outputs enabled");
  chk_flag_route: assert property (
    s_flag_steady |-> serial_out_pin_oe_o
      && serial_out_pin_o == jitter_store_error_i[0])
    else $error("error flag not routed");
  chk_hard_len: assert property (
    $rose(hard_reset_n_i) |-> ##[1:210] !in_reset_o)
    else $error("hard reset too long");
  chk_soft_len: assert property (
    $rose(in_reset_o) && hard_reset_n_i |-> ##[1:205] !in_reset_o)
    else $error("soft reset too long");
endmodule
bind lhs_core lhs_chk u_chk (.mclk_i, .rst_b_i, .hard_reset_n_i,
  .control_mode_strap_i, .chip_select_n_i, .jitter_store_error_i,
  .serial_out_pin_o, .serial_out_pin_oe_o, .hardware_mode_o, .in_reset_o,
  .host_outputs_enable_o, .hard_reset_hiz_o, .tx_clock_pin_dir_out_o,
  .chan_cfg_o, .global_config_register_o);

// ---- testbench/lhs_host_model.sv ----
// Host master model for the slave serial port
`timescale 1ns/100ps
module lhs_host_model (
  input wire logic mclk_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic dclk_o,
  output logic sel_n_o,
  output logic din_o
);
  initial begin
    dclk_o = 1'b0;
    sel_n_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic xfer(input logic sel, input logic [15:0] w,
    output logic [7:0] q);
    repeat (4) @(negedge mclk_i);
    sel_n_o = ~sel;
    for (int i = 15; i >= 0; i--) begin
      repeat (4) @(negedge mclk_i);
      dclk_o = 1'b1;
      din_o = w[i];
      repeat (4) @(negedge mclk_i);
      dclk_o = 1'b0;
      if (i < 8) q[i] = dout_oe_i ? dout_i : 1'bx;
    end
    repeat (4) @(negedge mclk_i);
    sel_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule

// ---- testbench/tb_lhs_core.sv ----
// Self-checking bench for the serial port and reset control
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_lhs_core;
  import lhs_pkg::*;
  logic mclk, rst_b, reference_clock_in, hard_n, strap, cs_n, sck, si, so, so_oe;
  logic hw_mode, in_rst, out_en, hiz;
  logic [3:0] jerr, txdir;
  logic [31:0] cfg;
  logic [7:0] global_config_register, q;
  logic [2:0] jds;
  logic jps;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [14:0] ROWS [4] = '{15'h105a, 15'h20a5, 15'h30ff,
    15'h4001};
  lhs_core #(.POR_LEN(20)) uut (.mclk_i(mclk), .rst_b_i(rst_b),
    .reference_clock_in_i(reference_clock_in), .hard_reset_n_i(hard_n),
    .control_mode_strap_i(strap), .chip_select_n_i(cs_n),
    .serial_clock_i(sck), .serial_in_pin_i(si),
    .jitter_store_error_i(jerr), .serial_out_pin_o(so),
    .serial_out_pin_oe_o(so_oe), .hardware_mode_o(hw_mode),
    .jitter_depth_select_o(jds), .jitter_path_select_o(jps),
    .in_reset_o(in_rst), .host_outputs_enable_o(out_en),
    .hard_reset_hiz_o(hiz), .tx_clock_pin_dir_out_o(txdir),
    .chan_cfg_o(cfg), .global_config_register_o(global_config_register));
  lhs_host_model host (.mclk_i(mclk), .dout_i(so), .dout_oe_i(so_oe),
    .dclk_o(sck), .sel_n_o(cs_n), .din_o(si));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) reference_clock_in <= ~reference_clock_in;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (in_rst !== 1'b0 && n < 260) begin
      @(negedge mclk);
      n++;
    end
    `CHK("in_reset", 1'b0, in_rst)
  endtask
  initial begin
    reference_clock_in = 1'b0;
    rst_b = 1'b0;
    hard_n = 1'b1;
    strap = 1'b0;
    jerr = 4'h0;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    wait_done();
    `CHK("cfg", 32'h0, cfg)
    `CHK("out_en", 1'b0, out_en)
    `CHK("txdir", 4'h0, txdir)
    `CHK("oe idle", 1'b0, so_oe)
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, {1'b0, ROWS[i]}, q);
      repeat (4) @(negedge mclk);
      `CHK("cfg byte", ROWS[i][7:0], cfg[i*8 +: 8])
      host.xfer(1'b1, {1'b1, ROWS[i][14:8], 8'h00}, q);
      `CHK("read", ROWS[i][7:0], q)
    end
    host.xfer(1'b0, 16'h1033, q);
    `CHK("deselected", 8'h5a, cfg[7:0])
    host.xfer(1'b1, 16'h0101, q);
    repeat (4) @(negedge mclk);
    `CHK("soft start", 1'b1, in_rst)
    wait_done();
    `CHK("soft cfg", 32'h0, cfg)
    `CHK("soft bit", 1'b0, global_config_register[0])
    host.xfer(1'b1, 16'h20a5, q);
    hard_n = 1'b0;
    repeat (8) @(negedge mclk);
    `CHK("hiz", 1'b1, hiz)
    `CHK("hard rst", 1'b1, in_rst)
    hard_n = 1'b1;
    wait_done();
    `CHK("hard cfg", 32'h0, cfg)
    strap = 1'b1;
    jerr = 4'h1;
    repeat (10) @(negedge mclk);
    `CHK("hw mode", 1'b1, hw_mode)
    `CHK("hw out_en", 1'b1, out_en)
    `CHK("flag", 1'b1, so)
    `CHK("flag oe", 1'b1, so_oe)
    `CHK("depth sel", {si, cs_n, 1'b0}, jds)
    `CHK("path sel", sck, jps)
    host.xfer(1'b1, 16'h1077, q);
    `CHK("hw ignore", 8'h00, cfg[7:0])
    report_and_stop();
  end
endmodule
